/* File: shared/ptmcc_pkg.sv */
package ptmcc_pkg;
  // Register indices (byte registers, one per 32-bit word)
  localparam logic [3:0] REG_CTRL0 = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_CTRL2 = 4'h2;
  localparam logic [3:0] REG_CNT_LO = 4'h3;
  localparam logic [3:0] REG_CNT_HI = 4'h4;
  localparam logic [3:0] REG_CMPA_LO = 4'h5;
  localparam logic [3:0] REG_CMPA_HI = 4'h6;
  localparam logic [3:0] REG_CAPB_LO = 4'h7;
  localparam logic [3:0] REG_CAPB_HI = 4'h8;
  localparam logic [3:0] REG_PER_LO = 4'h9;
  localparam logic [3:0] REG_PER_HI = 4'hA;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 4;
  // Control field positions
  localparam int C0_PAUSE = 7;
  localparam int C0_CKS_LSB = 4;
  localparam int C0_ON = 3;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_PIN_LSB = 4;
  localparam int C1_OLC = 3;
  localparam int C1_INV = 2;
  localparam int C1_CAPSRC = 1;
  localparam int C1_CLRSEL = 0;
  localparam int C2_CCLR_LSB = 1;
  localparam int C2_EDGE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] C0_WMASK = 8'hF8;
  localparam logic [7:0] C2_WMASK = 8'h06;
  // Prescale terminal counts
  localparam int DIV_SYS4 = 4;
  localparam int DIV_H16 = 16;
  localparam int DIV_H64 = 64;
  localparam int PRE_W = 6;

  typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} ptmcc_mode_type;
  typedef enum logic [2:0] {
    CK_SYS4, CK_SYS, CK_H16, CK_H64, CK_SUB0, CK_SUB1, CK_EXT_RISE, CK_EXT_FALL
  } ptmcc_clk_type;

  // Wishbone slave request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } ptmcc_wb_req_type;

  // Event flags toward the interrupt logic
  typedef struct packed {
    logic match_a_flag;
    logic match_p_flag;
  } ptmcc_flags_type;
endpackage

/* File: core/ptmcc_timer.sv */
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
// Operation
// R1: 10-bit up-counter on selected clock source
// R2: Comparators A and P watch counter
// R3: Counter cleared by timer_on rise
// R4: Auto clear on overflow, match, trigger
// R5: Pause bit holds counter value
// R6: Clock select picks counting clock
// R7: Timer off stops counter, keeps value
// R8: Timer_on rise restores initial output level
// R9: Mode field selects operating mode
// R10: Software turns timer off before mode change
// R11: Match A drives output per pin function
// R12: Level equal initial gives no change
// R13: PWM mode pin function selects output
// R14: Capture into compare A when clear 00
// R15: Capture into A/B when clear nonzero
// R16: Capture source pin or clock pin
// R17: Output control bit sets initial/active level
// R18: Software changes PWM pin function when off
// R19: Invert bit inverts output
// R20: Clear select: match A or P/overflow
// R21: Capture clear field selects counter clears
// R22: Latch edge flag reports capture edge
// R23: Flags set; no P flag when A clears
// R24: Counter advances once per qualified edge
module ptmcc_timer
  import ptmcc_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ptmcc_pkg::ptmcc_wb_req_type wb_req_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic high_clock_tick_in,
  input wire logic sub_clock_tick_in,
  input wire logic external_clock_pin_in,
  input wire logic capture_input_pin_in,
  output logic timer_out,
  output logic timer_oe_out,
  output ptmcc_pkg::ptmcc_flags_type flags_out
);
  import ptmcc_pkg::*;

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [2:0] ctrl2;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] cmp_a;
  logic [CNT_W-1:0] cap_b;
  logic [CNT_W-1:0] period;
  logic [PRE_W-1:0] pre_sys;
  logic [PRE_W-1:0] pre_h;
  logic ext_q;
  logic cap_q;
  logic on_q;
  logic out_lvl;
  logic pwm_lvl;
  logic pulse_done;
  logic next_tick;
  logic on_rise;
  logic hw_off;
  logic ext_rise;
  logic ext_fall;
  logic trig_rise;
  logic trig_fall;
  logic match_a;
  logic match_p;
  logic overflow;
  logic cnt_clear;
  logic wr_stb;
  logic [IDX_W-1:0] idx;
  logic [7:0] wbyte;
  ptmcc_mode_type mode;
  ptmcc_clk_type cks;
  logic [1:0] pin_fn;
  logic [1:0] cap_clr;
  logic cap_src;

  assign mode = ptmcc_mode_type'(ctrl1[C1_MODE_LSB +: 2]); // [R9]
  assign cks = ptmcc_clk_type'(ctrl0[C0_CKS_LSB +: 3]);
  assign pin_fn = ctrl1[C1_PIN_LSB +: 2];
  assign cap_clr = ctrl2[C2_CCLR_LSB +: 2];
  assign cap_src = ctrl1[C1_CAPSRC];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, dropped the cycle after
  assign idx = wb_req_in.adr[ADDR_LSB +: IDX_W];
  assign wbyte = wb_req_in.dat[7:0];
  assign wr_stb = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !wb_ack_out
                  && wb_req_in.sel[0] && clk_en_in;

  // Ack pulse; unmapped addresses still ack and read zero
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wb_ack_out <= 1'b0;
    else if (clk_en_in)
      wb_ack_out <= wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  end

  // Read data mux, registered
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wb_dat_out <= 32'h0000_0000;
    else if (clk_en_in)
    begin
      wb_dat_out <= 32'h0000_0000;
      case (idx)
        REG_CTRL0: wb_dat_out[7:0] <= ctrl0 & C0_WMASK;
        REG_CTRL1: wb_dat_out[7:0] <= ctrl1;
        REG_CTRL2: wb_dat_out[2:0] <= ctrl2;
        REG_CNT_LO: wb_dat_out[7:0] <= count[7:0];
        REG_CNT_HI: wb_dat_out[CNT_W-9:0] <= count[CNT_W-1:8];
        REG_CMPA_LO: wb_dat_out[7:0] <= cmp_a[7:0];
        REG_CMPA_HI: wb_dat_out[CNT_W-9:0] <= cmp_a[CNT_W-1:8];
        REG_CAPB_LO: wb_dat_out[7:0] <= cap_b[7:0];
        REG_CAPB_HI: wb_dat_out[CNT_W-9:0] <= cap_b[CNT_W-1:8];
        REG_PER_LO: wb_dat_out[7:0] <= period[7:0];
        REG_PER_HI: wb_dat_out[CNT_W-9:0] <= period[CNT_W-1:8];
        default: wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; single pulse match A clears timer_on itself
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl0 <= CTRL_RESET;
      ctrl1 <= CTRL_RESET;
    end
    else if (clk_en_in)
    begin
      if (wr_stb && idx == REG_CTRL0)
        ctrl0 <= wbyte & C0_WMASK;
      else if (hw_off)
        ctrl0[C0_ON] <= 1'b0;
      else if (mode == MODE_PWM && pin_fn == 2'b11 && !ctrl0[C0_ON] && ext_rise)
        ctrl0[C0_ON] <= 1'b1; // Clock pin edge starts a single pulse
      if (wr_stb && idx == REG_CTRL1)
        ctrl1 <= wbyte;
    end
  end

  // Capture clear field; latch edge flag is hardware owned, moved only by capturing edges [R22]
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ctrl2 <= 3'b000;
    else if (clk_en_in)
    begin
      if (wr_stb && idx == REG_CTRL2)
        ctrl2[2:1] <= wbyte[2:1];
      if (mode == MODE_CAP && ctrl0[C0_ON] && pin_fn != 2'b11)
      begin
        if (trig_rise && pin_fn != 2'b01)
          ctrl2[C2_EDGE] <= 1'b1; // [R22]
        else if (trig_fall && pin_fn != 2'b00)
          ctrl2[C2_EDGE] <= 1'b0; // [R22]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers and edge detectors; pins are synchronous already
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pre_sys <= '0;
      pre_h <= '0;
      ext_q <= 1'b0;
      cap_q <= 1'b0;
      on_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pre_sys <= (pre_sys == PRE_W'(DIV_SYS4 - 1)) ? '0 : pre_sys + 1'b1;
      if (high_clock_tick_in)
        pre_h <= pre_h + 1'b1;
      ext_q <= external_clock_pin_in;
      cap_q <= capture_input_pin_in;
      on_q <= ctrl0[C0_ON];
    end
  end

  assign ext_rise = external_clock_pin_in && !ext_q;
  assign ext_fall = !external_clock_pin_in && ext_q;
  assign on_rise = ctrl0[C0_ON] && !on_q;
  // Trigger source select [R16]
  assign trig_rise = cap_src ? ext_rise : (capture_input_pin_in && !cap_q);
  assign trig_fall = cap_src ? ext_fall : (!capture_input_pin_in && cap_q);

  // Count clock select; gated prescalers cost less than extra clock domains
  always_comb
  begin
    next_tick = 1'b0;
    case (cks) // [R6]
      CK_SYS4: next_tick = (pre_sys == PRE_W'(DIV_SYS4 - 1));
      CK_SYS: next_tick = 1'b1;
      CK_H16: next_tick = high_clock_tick_in && (pre_h[3:0] == 4'(DIV_H16 - 1));
      CK_H64: next_tick = high_clock_tick_in && (pre_h == PRE_W'(DIV_H64 - 1));
      CK_SUB0, CK_SUB1: next_tick = sub_clock_tick_in;
      CK_EXT_RISE: next_tick = ext_rise;
      CK_EXT_FALL: next_tick = ext_fall;
      default: next_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators; period zero means full 1024 count
  assign match_a = next_tick && (count == cmp_a); // [R2]
  assign match_p = next_tick && (count == period - 1'b1) && (period != '0); // [R2]
  assign overflow = next_tick && (&count);
  assign hw_off = ctrl0[C0_ON] && !ctrl0[C0_PAUSE] && mode == MODE_PWM
                  && pin_fn == 2'b11 && match_a;

  // Clear condition per mode; a zero compare A never clears, so the count wraps
  always_comb
  begin
    cnt_clear = 1'b0;
    case (mode)
      MODE_CMP, MODE_TMR: cnt_clear = ctrl1[C1_CLRSEL] ? (match_a && cmp_a != '0)
                                      : (match_p || overflow); // [R20]
      MODE_CAP: cnt_clear = match_p || overflow
                            || (cap_clr[0] && trig_rise)
                            || (cap_clr[1] && trig_fall); // [R21] [R4]
      MODE_PWM: cnt_clear = match_p || overflow;
      default: cnt_clear = 1'b0;
    endcase
  end

  // Counter: cleared on turn-on, held when off or paused
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      count <= '0;
    else if (clk_en_in)
    begin
      if (on_rise)
        count <= '0; // [R3]
      else if (ctrl0[C0_ON] && !ctrl0[C0_PAUSE]) // [R5] [R7]
      begin
        if (mode == MODE_CAP && cnt_clear)
          count <= '0; // [R4]
        else if (next_tick)
          count <= cnt_clear ? '0 : count + 1'b1; // [R1] [R24] [R4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, capture and period registers; capture in capture mode
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cmp_a <= '0;
      cap_b <= '0;
      period <= '0;
    end
    else if (clk_en_in)
    begin
      if (wr_stb && idx == REG_CMPA_LO) cmp_a[7:0] <= wbyte;
      if (wr_stb && idx == REG_CMPA_HI) cmp_a[CNT_W-1:8] <= wbyte[CNT_W-9:0];
      if (wr_stb && idx == REG_CAPB_LO) cap_b[7:0] <= wbyte;
      if (wr_stb && idx == REG_CAPB_HI) cap_b[CNT_W-1:8] <= wbyte[CNT_W-9:0];
      if (wr_stb && idx == REG_PER_LO) period[7:0] <= wbyte;
      if (wr_stb && idx == REG_PER_HI) period[CNT_W-1:8] <= wbyte[CNT_W-9:0];
      if (mode == MODE_CAP && ctrl0[C0_ON] && pin_fn != 2'b11)
      begin
        if (cap_clr == 2'b00)
        begin
          if ((pin_fn != 2'b01 && trig_rise) || (pin_fn != 2'b00 && trig_fall))
            cmp_a <= count; // [R14]
        end
        else
        begin
          if (pin_fn != 2'b01 && trig_rise)
            cap_b <= count; // [R15]
          if (pin_fn != 2'b00 && trig_fall)
            cmp_a <= count; // [R15]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags; P flag suppressed when match A clears [R23]
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      flags_out <= '0;
    else if (clk_en_in)
    begin
      flags_out.match_a_flag <= ctrl0[C0_ON] && !ctrl0[C0_PAUSE]
                                && (mode == MODE_CAP ? ((trig_rise && pin_fn != 2'b01)
                                    || (trig_fall && pin_fn != 2'b00)) && pin_fn != 2'b11
                                    : match_a && cmp_a != '0);
      flags_out.match_p_flag <= ctrl0[C0_ON] && !ctrl0[C0_PAUSE] && (match_p || overflow)
                                && !((mode == MODE_CMP || mode == MODE_TMR)
                                     && ctrl1[C1_CLRSEL]); // [R23]
    end
  end

  // Output state: compare-match level, PWM level and single-pulse state
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_lvl <= 1'b0;
      pwm_lvl <= 1'b0;
      pulse_done <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (on_rise)
      begin
        out_lvl <= ctrl1[C1_OLC]; // [R8] [R17]
        pwm_lvl <= 1'b1;
        pulse_done <= 1'b0;
      end
      else if (ctrl0[C0_ON] && !ctrl0[C0_PAUSE])
      begin
        if (mode == MODE_CMP && match_a && cmp_a != '0)
        begin
          case (pin_fn) // [R11] [R12]
            2'b01: out_lvl <= 1'b0;
            2'b10: out_lvl <= 1'b1;
            2'b11: out_lvl <= !out_lvl;
            default: out_lvl <= out_lvl;
          endcase
        end
        if (match_p || overflow)
          pwm_lvl <= 1'b1;
        else if (match_a)
          pwm_lvl <= 1'b0; // Duty ends at match A
      end
      if (hw_off)
        pulse_done <= 1'b1;
    end
  end

  // Pin drive: active level and inversion; undriven in capture and timer/counter modes
  always_comb
  begin
    logic lvl;
    lvl = 1'b0;
    case (mode)
      MODE_CMP: lvl = out_lvl;
      MODE_PWM:
        case (pin_fn) // [R13]
          2'b00: lvl = !ctrl1[C1_OLC];
          2'b01: lvl = ctrl1[C1_OLC];
          2'b10: lvl = pwm_lvl ? ctrl1[C1_OLC] : !ctrl1[C1_OLC]; // [R17]
          default: lvl = (ctrl0[C0_ON] && !pulse_done) ? ctrl1[C1_OLC]
                         : !ctrl1[C1_OLC];
        endcase
      default: lvl = 1'b0;
    endcase
    timer_out = lvl ^ ctrl1[C1_INV]; // [R19]
    timer_oe_out = (mode == MODE_CMP || mode == MODE_PWM); // [R9]
  end
endmodule

/* File: tb/ptmcc_timer_asserts.sv */
`timescale 1ns/1ns
module ptmcc_chk
  import ptmcc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ptmcc_pkg::ptmcc_wb_req_type wb_req_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic timer_out,
  input wire logic timer_oe_out,
  input wire ptmcc_pkg::ptmcc_flags_type flags_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] c0;
  logic [7:0] c1;
  logic [1:0] wr_q;
  wire take = wb_req_in.cyc & wb_req_in.stb & !wb_ack_out & clk_en_in;
  wire wr = take & wb_req_in.we & wb_req_in.sel[0];
  wire [3:0] idx = wb_req_in.adr[ADDR_LSB +: IDX_W];
  wire [1:0] md = c1[7:6];
  wire stop = !c0[C0_ON] | c0[C0_PAUSE];
  // Shadow control bytes; hardware clears of timer_on only make checks idle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      wr_q <= 2'h0;
    end
    else
    begin
      wr_q <= {wr_q[0], wr};
      if (wr && idx == REG_CTRL0)
        c0 <= wb_req_in.dat[7:0] & C0_WMASK;
      if (wr && idx == REG_CTRL1)
        c1 <= wb_req_in.dat[7:0];
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_ack;
    take |=> wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  property p_ack_drop;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");
  property p_dat;
    wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000;
  endproperty
  a_dat: assert property (p_dat) else $error("read data upper bits set");
  property p_oe;
    timer_oe_out == (md == MODE_CMP || md == MODE_PWM);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_force;
    md == MODE_PWM && !c1[5] |-> timer_out == ((c1[4] ? c1[3] : !c1[3]) ^ c1[2]);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");
  // Turn-on is seen one edge after the write, the new level one edge later
  property p_on_rise;
    wr && idx == REG_CTRL0 && wb_req_in.dat[C0_ON] && !c0[C0_ON] && md == MODE_CMP
      |-> ##2 timer_out == (c1[C1_OLC] ^ c1[C1_INV]);
  endproperty
  a_on_rise: assert property (p_on_rise) else $error("no initial level");
  // Two quiet cycles after any write, so a turn-on reload is not taken as a match
  property p_hold;
    md == MODE_CMP && c1[5:4] == 2'h0 && wr_q == 2'h0 |-> $stable(timer_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_no_p;
    md == MODE_CMP && c1[C1_CLRSEL] && $stable(c1) |-> !flags_out.match_p_flag;
  endproperty
  a_no_p: assert property (p_no_p) else $error("P flag on A clear");
  property p_idle;
    md[0] == md[1] && stop && $past(stop) |-> flags_out == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("flag while stopped");
endmodule

/* File: tb/ptmcc_pins.sv */
`timescale 1ns/1ns
module ptmcc_pins
(
  input wire logic mclk_in,
  output logic high_tick_out,
  output logic sub_tick_out,
  output logic ext_pin_out,
  output logic cap_pin_out
);
  logic [3:0] n = 4'h0;
  // Tick sources: high clock every 2nd cycle, sub clock every 5th
  always @(posedge mclk_in)
    n <= (n == 4'h9) ? 4'h0 : n + 4'h1;
  assign high_tick_out = n[0];
  assign sub_tick_out = (n == 4'h0) || (n == 4'h5);
  // Pins are plain levels, idle low until a scenario moves them
  initial
  begin
    ext_pin_out = 1'b0;
    cap_pin_out = 1'b0;
  end
  task automatic put(input logic src, input logic lvl);
    @(posedge mclk_in);
    if (src)
      ext_pin_out <= lvl;
    else
      cap_pin_out <= lvl;
  endtask
  // Four cycles apart, so every edge is seen on its own
  task automatic toggle(input int k);
    repeat (k)
    begin
      repeat (4) @(posedge mclk_in);
      ext_pin_out <= !ext_pin_out;
    end
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  import ptmcc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  ptmcc_wb_req_type req = '0;
  logic [31:0] rdat;
  logic ack, tout, toe, hck, sck, ext, cap, tprev;
  ptmcc_flags_type flg;
  int errors = 0, n_tests = 0, na = 0, np = 0, nt = 0, i;
  int ex[8] = '{100, 400, 12, 3, 80, 80, 20, 20};
  int tl[8] = '{3, 4, 2, 2, 3, 3, 1, 1};
  ptmcc_timer uut (.mclk_in(mclk), .rst_b_in(rst_b), .clk_en_in(clk_en), .wb_req_in(req),
    .wb_dat_out(rdat), .wb_ack_out(ack), .high_clock_tick_in(hck), .sub_clock_tick_in(sck),
    .external_clock_pin_in(ext), .capture_input_pin_in(cap), .timer_out(tout),
    .timer_oe_out(toe), .flags_out(flg));
  ptmcc_pins far (.mclk_in(mclk), .high_tick_out(hck), .sub_tick_out(sck),
    .ext_pin_out(ext), .cap_pin_out(cap));
  initial
  begin
    forever #25 mclk = !mclk;
  end
  // Count events on the falling edge, clear of the bench's own updates
  always @(negedge mclk)
  begin
    na += flg.match_a_flag;
    np += flg.match_p_flag;
    nt += (tout !== tprev);
    tprev = tout;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; never assumes the answer latency
  task automatic wb(input logic we, input logic [3:0] x, input logic [7:0] d,
    output logic [7:0] q);
    int k;
    @(posedge mclk);
    req <= '{1'b1, 1'b1, we, 4'h1, 32'(x) << ADDR_LSB, {24'h00_0000, d}};
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat[7:0];
    req <= '0;
    if (k >= 20)
    begin
      errors++;
      final_report();
    end
  endtask
  task automatic w(input logic [3:0] x, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, x, d, q);
  endtask
  task automatic rd10(input logic [3:0] x, output logic [9:0] v);
    logic [7:0] l, h;
    wb(1'b0, x, 8'h00, l);
    wb(1'b0, x + 4'h1, 8'h00, h);
    v = {h[1:0], l};
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    logic [7:0] q;
    for (i = 0; i < 16; i++)
    begin
      wb(1'b0, i[3:0], 8'h00, q);
      chk(q, 0);
    end
    w(REG_CTRL0, 8'hFF);
    w(REG_CTRL2, 8'hFF);
    w(REG_CNT_LO, 8'h55);
    wb(1'b0, REG_CTRL0, 8'h00, q);
    chk(q, 8'hF8);
    wb(1'b0, REG_CTRL2, 8'h00, q);
    chk(q, 8'h06);
    wb(1'b0, REG_CNT_LO, 8'h00, q);
    chk(q, 0);
    w(REG_CTRL0, 8'h00);
    w(REG_CTRL2, 8'h00);
  endtask
  task automatic s_rate(input logic [2:0] k, input int e, input int t);
    logic [9:0] v, v2;
    w(REG_CTRL0, {1'h0, k, 4'h8});
    if (k[2] & k[1])
      far.toggle(40);
    else
      repeat (400) @(posedge mclk);
    w(REG_CTRL0, {1'h0, k, 4'h0});
    rd10(REG_CNT_LO, v);
    chk(v >= e - t && v <= e + t, 1);
    repeat (20) @(posedge mclk);
    rd10(REG_CNT_LO, v2);
    chk(v2, v);
  endtask
  task automatic s_pause();
    logic [9:0] a, b, c;
    w(REG_CTRL0, 8'h18);
    repeat (100) @(posedge mclk);
    w(REG_CTRL0, 8'h98);
    rd10(REG_CNT_LO, a);
    repeat (50) @(posedge mclk);
    rd10(REG_CNT_LO, b);
    chk(b, a);
    w(REG_CTRL0, 8'h18);
    // Clock enable low must freeze the count, so these cycles add nothing
    clk_en <= 1'b0;
    repeat (20) @(posedge mclk);
    clk_en <= 1'b1;
    repeat (50) @(posedge mclk);
    w(REG_CTRL0, 8'h98);
    rd10(REG_CNT_LO, c);
    chk(c >= a + 50 && c <= a + 56, 1);
    w(REG_CTRL0, 8'h10);
    w(REG_CTRL0, 8'h18);
    rd10(REG_CNT_LO, c);
    chk(c < 8, 1);
    w(REG_CTRL0, 8'h10);
  endtask
  // A negative toggle count -n means n output changes per A match
  task automatic s_cmp(input logic [7:0] c1, input logic [7:0] p, input int alo,
    input int ahi, input int pe, input int t);
    w(REG_PER_LO, p);
    w(REG_CTRL1, c1);
    w(REG_CTRL0, 8'h18);
    repeat (2) @(posedge mclk);
    na = 0;
    np = 0;
    nt = 0;
    repeat (210) @(posedge mclk);
    w(REG_CTRL0, 8'h10);
    chk(na >= alo && na <= ahi, 1);
    chk(pe == 0 ? np == 0 : np >= pe - 2 && np <= pe + 1, 1);
    chk(t < 0 ? (nt + 1 >= -t * na && nt <= 1 - t * na) : nt == t, 1);
  endtask
  // Pins move before reconfiguring; captures are wiped after that
  task automatic s_cap(input logic [1:0] pin, input logic src, input logic [1:0] c2,
    input logic rise, input logic ina, input logic inb);
    logic [9:0] a, b, c;
    logic [7:0] f;
    far.put(src, !rise);
    w(REG_CTRL1, {2'h1, pin, 2'h0, src, 1'h0});
    w(REG_CTRL2, {5'h00, c2, 1'h0});
    w(REG_CMPA_LO, 8'h00);
    w(REG_CAPB_LO, 8'h00);
    w(REG_CTRL0, 8'h18);
    repeat (100) @(posedge mclk);
    far.put(src, rise);
    repeat (3) @(posedge mclk);
    w(REG_CTRL0, 8'h10);
    rd10(REG_CMPA_LO, a);
    rd10(REG_CAPB_LO, b);
    rd10(REG_CNT_LO, c);
    wb(1'b0, REG_CTRL2, 8'h00, f);
    chk(ina ? (a >= 98 && a <= 108) : a == 0, 1);
    chk(inb ? (b >= 98 && b <= 108) : b == 0, 1);
    chk(c2 != 0 ? c < 10 : c > 100, 1);
    if (c2 != 0)
      chk(f[0], rise);
  endtask
  task automatic s_pins();
    for (i = 0; i < 4; i++)
    begin
      w(REG_CTRL1, {i[1:0], 6'h00});
      chk(toe, i == 0 || i == 2);
    end
    for (i = 0; i < 8; i++)
    begin
      w(REG_CTRL1, {3'h4, i[2:0], 2'h0});
      chk(tout, (i[1] ? i[2] : !i[2]) ^ i[0]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    s_regs();
    for (int j = 0; j < 8; j++)
      s_rate(j[2:0], ex[j], tl[j]);
    s_pause();
    w(REG_CMPA_LO, 8'h14);
    s_cmp(8'h31, 8'h00, 9, 11, 0, -1);
    s_cmp(8'h30, 8'h0A, 0, 0, 21, 0);
    s_cmp(8'hA8, 8'h1E, 6, 8, 7, -2);
    s_cmp(8'h11, 8'h00, 9, 11, 0, 0);
    s_cmp(8'hB8, 8'h00, 1, 1, 0, 1);
    s_cmp(8'h21, 8'h00, 9, 11, 0, 1);
    s_cap(2'h0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0);
    s_cap(2'h0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1);
    s_cap(2'h1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
    s_cap(2'h2, 1'b0, 2'h3, 1'b1, 1'b0, 1'b1);
    s_cap(2'h3, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
    s_pins();
    final_report();
  end
endmodule
bind ptmcc_timer ptmcc_chk chk (.mclk_in, .rst_b_in, .clk_en_in, .wb_req_in, .wb_dat_out,
  .wb_ack_out, .timer_out, .timer_oe_out, .flags_out);
